// file: evt_ctrl_pkg.sv
// shared constants and types for the watchdog, interrupt and sleep controller
package evt_ctrl_pkg;
    localparam int NUM_SRC = 5;
    localparam int NUM_PINS = 6;

    localparam logic [5:0] ADR_IRQ_EN = 6'h00;
    localparam logic [5:0] ADR_IRQ_REQ = 6'h04;
    localparam logic [5:0] ADR_EDGE = 6'h08;
    localparam logic [5:0] ADR_OPTION = 6'h0C;
    localparam logic [5:0] ADR_SP = 6'h10;
    localparam logic [5:0] ADR_CMD = 6'h14;
    localparam logic [5:0] ADR_STATUS = 6'h18;
    localparam logic [5:0] ADR_WDT = 6'h1C;
    localparam logic [5:0] ADR_CMP_CTRL = 6'h20;
    localparam logic [5:0] ADR_CMP_SEL = 6'h24;
    localparam logic [5:0] ADR_PIN_WAKE = 6'h28;

    localparam int OPT_WDT_LSB = 0;
    localparam int OPT_FAST_BIT = 5;
    localparam int CMP_EN_BIT = 7;
    localparam int CMP_WAKE_BIT = 6;

    localparam int CMD_WDT_CLR = 0;
    localparam int CMD_GIE_ON = 1;
    localparam int CMD_GIE_OFF = 2;
    localparam int CMD_LIGHT = 3;
    localparam int CMD_DEEP = 4;
    localparam int CMD_RETI = 5;

    localparam logic [18:0] WDT_LIMIT_8K = 19'h02000;
    localparam logic [18:0] WDT_LIMIT_16K = 19'h04000;
    localparam logic [18:0] WDT_LIMIT_64K = 19'h10000;
    localparam logic [18:0] WDT_LIMIT_256K = 19'h40000;
    localparam logic [11:0] WAKE_NORMAL = 12'hBB8;
    localparam logic [11:0] WAKE_FAST = 12'h02D;

    localparam logic [15:0] IRQ_VECTOR = 16'h0010;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [7:0] SP_STEP = 8'h02;

    localparam logic [7:0] OPT_RESET = 8'h00;
    localparam logic [9:0] EDGE_RESET = 10'h000;
    localparam logic [4:0] EN_RESET = 5'h00;
    localparam logic [4:0] REQ_RESET = 5'h00;
    localparam logic [7:0] SP_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [5:0] PIN_WAKE_RESET = 6'h00;

    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [15:0] wdata;
    } stack_req_t;

    typedef struct packed {
        logic load;
        logic [15:0] target;
    } pc_redirect_t;

    typedef enum logic [3:0] {
        PWR_RUN = 4'h1,
        PWR_LIGHT = 4'h2,
        PWR_DEEP = 4'h4,
        PWR_WAKE = 4'h8
    } pwr_state_t;

    function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0] sel);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_lanes

    function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                      input logic fall);
        case (sel)
            EDGE_RISE: edge_hit = rise;
            EDGE_FALL: edge_hit = fall;
            default: edge_hit = rise | fall;
        endcase
    endfunction : edge_hit
endpackage : evt_ctrl_pkg

// file: edge_sync.sv
// two-flop synchroniser with edge detection for pins and the slow oscillator
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;
    logic [W-1:0] prev_reg;

    // only stage2 looks at stage1, the edge logic sees settled values
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            prev_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            prev_reg <= stage2_reg;
        end
    end

    assign level = stage2_reg;
    assign rise = stage2_reg & ~prev_reg;
    assign fall = ~stage2_reg & prev_reg;
endmodule : edge_sync
`default_nettype wire

// file: evt_ctrl.sv
// watchdog, interrupt controller and sleep/wake sequencer with a wishbone slave
// What this block does
// - watchdog counts slow RC clocks, cleared by power-on reset or clear command
// - option bits 1:0 pick timeout 8k, 16k, 64k or 256k; default 8k
// - watchdog reaching its timeout resets the chip and restarts the program
// - first watchdog period after wake may be short; firmware clears it
// - five interrupt sources, each with its own enable bit
// - hardware sets request flags; only a software write clears them
// - each source triggers on rising, falling or both edges
// - global enable gates all requests; on and off commands set and clear it
// - request flags set even when the source is disabled
// - entry pushes pc at stack pointer, adds 2, clears global enable, jumps 0x010
// - return pops pc, subtracts 2, sets global enable, resumes interrupted code
// - light sleep stops the system clock and program memory; oscillators stay as they are
// - in light sleep timers on system clock or dead oscillator stop
// - light sleep wakes on pin toggle, timer hit or enabled comparator event
// - deep sleep stops oscillators and program memory; wakes on pin toggle only
// - timer and comparator wake only in light sleep; pins wake both
// - wake delay is 3000 slow clocks normal or 45 fast, by option bit 5
// - fast boot build option forces fast wake timing
// - after pin wake execution continues after the sleep instruction
`timescale 1ns/1ps
`default_nettype none
module evt_ctrl #(
    parameter bit FAST_BOOT = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic low_speed_rc_osc,
    input wire logic ext_irq_pin,
    input wire logic [5:0] wake_pin,
    input wire logic [5:0] pin_is_output,
    input wire logic [3:0] src_level,
    input wire logic cpu_boundary,
    input wire logic [15:0] cpu_pc,
    input wire logic [15:0] stack_rd_data,
    input wire logic [4:0] timer_hit,
    input wire logic [4:0] timer_on_sysclk,
    input wire logic [4:0] timer_osc_on,
    input wire logic cmp_event,
    output logic chip_reset,
    output evt_ctrl_pkg::stack_req_t stack_req,
    output evt_ctrl_pkg::pc_redirect_t pc_redirect,
    output logic sys_clk_en,
    output logic osc_stop,
    output logic prog_mem_off,
    output logic [4:0] timer_run
);
    logic [4:0] irq_en_reg;
    logic [4:0] irq_req_reg;
    logic [9:0] edge_sel_reg;
    logic [7:0] option_reg;
    logic [7:0] sp_reg;
    logic [7:0] cmp_ctrl_reg;
    logic [7:0] cmp_sel_reg;
    logic [5:0] pin_wake_reg;
    logic gie_reg;
    logic ret_phase_reg;
    logic [17:0] wdt_cnt_reg;
    logic [11:0] wake_cnt_reg;
    logic [3:0] src_prev_reg;
    evt_ctrl_pkg::pwr_state_t pwr_reg;
    evt_ctrl_pkg::pwr_state_t pwr_next;

    logic lrc_tick;
    logic [6:0] pin_rise;
    logic [6:0] pin_fall;
    logic [4:0] src_rise;
    logic [4:0] src_fall;
    logic [4:0] events;
    logic [31:0] rd_mux;
    logic [31:0] wr_word;
    logic bus_req;
    logic bus_wr;
    logic [5:0] cmd;
    logic [18:0] wdt_limit;
    logic [11:0] wake_limit;
    logic wdt_fire;
    logic pin_toggle;
    logic light_wake;
    logic take_irq;

    edge_sync #(.W(1)) lrc_sync (
        .clk(clk),
        .reset(reset),
        .async_in(low_speed_rc_osc),
        .level(),
        .rise(lrc_tick),
        .fall()
    );

    edge_sync #(.W(7)) pin_sync (
        .clk(clk),
        .reset(reset),
        .async_in({wake_pin, ext_irq_pin}),
        .level(),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // ---------------- wishbone slave ----------------
    assign bus_req = wb_cyc_i & wb_stb_i;
    // a write lands on the edge where the master sees ack
    assign bus_wr = bus_req & wb_we_i & wb_ack_o;
    assign wr_word = evt_ctrl_pkg::merge_lanes(rd_mux, wb_dat_i, wb_sel_i);
    assign cmd = (bus_wr && wb_adr_i == evt_ctrl_pkg::ADR_CMD && wb_sel_i[0]) ?
                 wb_dat_i[5:0] : 6'h00;

    always_comb begin
        case (wb_adr_i)
            evt_ctrl_pkg::ADR_IRQ_EN: rd_mux = {27'h0, irq_en_reg};
            evt_ctrl_pkg::ADR_IRQ_REQ: rd_mux = {27'h0, irq_req_reg};
            evt_ctrl_pkg::ADR_EDGE: rd_mux = {22'h0, edge_sel_reg};
            evt_ctrl_pkg::ADR_OPTION: rd_mux = {24'h0, option_reg};
            evt_ctrl_pkg::ADR_SP: rd_mux = {24'h0, sp_reg};
            evt_ctrl_pkg::ADR_STATUS: rd_mux = {24'h0, pwr_reg, 3'h0, gie_reg};
            evt_ctrl_pkg::ADR_WDT: rd_mux = {14'h0, wdt_cnt_reg};
            evt_ctrl_pkg::ADR_CMP_CTRL: rd_mux = {24'h0, cmp_ctrl_reg};
            evt_ctrl_pkg::ADR_CMP_SEL: rd_mux = {24'h0, cmp_sel_reg};
            evt_ctrl_pkg::ADR_PIN_WAKE: rd_mux = {26'h0, pin_wake_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req && !wb_ack_o) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_en_reg <= evt_ctrl_pkg::EN_RESET;
            edge_sel_reg <= evt_ctrl_pkg::EDGE_RESET;
            option_reg <= evt_ctrl_pkg::OPT_RESET;
            cmp_ctrl_reg <= evt_ctrl_pkg::CMP_RESET;
            cmp_sel_reg <= evt_ctrl_pkg::CMP_RESET;
            pin_wake_reg <= evt_ctrl_pkg::PIN_WAKE_RESET;
        end else if (bus_wr) begin
            case (wb_adr_i)
                evt_ctrl_pkg::ADR_IRQ_EN: irq_en_reg <= wr_word[4:0];
                evt_ctrl_pkg::ADR_EDGE: edge_sel_reg <= wr_word[9:0];
                evt_ctrl_pkg::ADR_OPTION: option_reg <= wr_word[7:0];
                evt_ctrl_pkg::ADR_CMP_CTRL: cmp_ctrl_reg <= wr_word[7:0];
                evt_ctrl_pkg::ADR_CMP_SEL: cmp_sel_reg <= wr_word[7:0];
                evt_ctrl_pkg::ADR_PIN_WAKE: pin_wake_reg <= wr_word[5:0];
                default: ;
            endcase
        end
    end

    // ---------------- watchdog ----------------
    always_comb begin
        case (option_reg[evt_ctrl_pkg::OPT_WDT_LSB +: 2])
            2'h1: wdt_limit = evt_ctrl_pkg::WDT_LIMIT_16K;
            2'h2: wdt_limit = evt_ctrl_pkg::WDT_LIMIT_64K;
            2'h3: wdt_limit = evt_ctrl_pkg::WDT_LIMIT_256K;
            default: wdt_limit = evt_ctrl_pkg::WDT_LIMIT_8K;
        endcase
    end

    // the 256k limit needs a nineteenth bit, the count itself stops one short of it
    assign wdt_fire = lrc_tick && (wdt_cnt_reg == 18'(wdt_limit - 19'h00001));

    // wake does not clear the count, so the first period after it can be short
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wdt_cnt_reg <= 18'h00000;
        end else if (cmd[evt_ctrl_pkg::CMD_WDT_CLR] || wdt_fire) begin
            wdt_cnt_reg <= 18'h00000;
        end else if (lrc_tick) begin
            wdt_cnt_reg <= wdt_cnt_reg + 18'h00001;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chip_reset <= 1'b0;
        end else begin
            chip_reset <= wdt_fire;
        end
    end

    // ---------------- interrupt flags ----------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            src_prev_reg <= 4'h0;
        end else begin
            src_prev_reg <= src_level;
        end
    end

    assign src_rise = {src_level & ~src_prev_reg, pin_rise[0]};
    assign src_fall = {~src_level & src_prev_reg, pin_fall[0]};

    always_comb begin
        for (int i = 0; i < evt_ctrl_pkg::NUM_SRC; i++) begin
            events[i] = evt_ctrl_pkg::edge_hit(edge_sel_reg[2*i +: 2], src_rise[i],
                                               src_fall[i]);
        end
    end

    // a new event wins over a software clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_req_reg <= evt_ctrl_pkg::REQ_RESET;
        end else if (bus_wr && wb_adr_i == evt_ctrl_pkg::ADR_IRQ_REQ) begin
            irq_req_reg <= wr_word[4:0] | events;
        end else begin
            irq_req_reg <= irq_req_reg | events;
        end
    end

    assign take_irq = (pwr_reg == evt_ctrl_pkg::PWR_RUN) && cpu_boundary && gie_reg &&
                      (|(irq_req_reg & irq_en_reg)) && (cmd == 6'h00) &&
                      !ret_phase_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gie_reg <= 1'b0;
        end else if (take_irq || cmd[evt_ctrl_pkg::CMD_GIE_OFF]) begin
            gie_reg <= 1'b0;
        end else if (cmd[evt_ctrl_pkg::CMD_GIE_ON] || cmd[evt_ctrl_pkg::CMD_RETI]) begin
            gie_reg <= 1'b1;
        end
    end

    // the stack steps by a whole pc word, so firmware keeps the pointer even
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sp_reg <= evt_ctrl_pkg::SP_RESET;
        end else if (take_irq) begin
            sp_reg <= sp_reg + evt_ctrl_pkg::SP_STEP;
        end else if (cmd[evt_ctrl_pkg::CMD_RETI]) begin
            sp_reg <= sp_reg - evt_ctrl_pkg::SP_STEP;
        end else if (bus_wr && wb_adr_i == evt_ctrl_pkg::ADR_SP) begin
            sp_reg <= wr_word[7:0];
        end
    end

    // stack memory answers in the same cycle as rd_en
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stack_req <= '0;
            pc_redirect <= '0;
            ret_phase_reg <= 1'b0;
        end else begin
            stack_req.wr_en <= take_irq;
            stack_req.rd_en <= cmd[evt_ctrl_pkg::CMD_RETI];
            ret_phase_reg <= cmd[evt_ctrl_pkg::CMD_RETI];
            if (take_irq) begin
                stack_req.addr <= sp_reg;
                stack_req.wdata <= cpu_pc;
            end else if (cmd[evt_ctrl_pkg::CMD_RETI]) begin
                stack_req.addr <= sp_reg - evt_ctrl_pkg::SP_STEP;
            end
            pc_redirect.load <= take_irq | ret_phase_reg | wdt_fire;
            if (wdt_fire) begin
                pc_redirect.target <= evt_ctrl_pkg::RESET_VECTOR;
            end else if (take_irq) begin
                pc_redirect.target <= evt_ctrl_pkg::IRQ_VECTOR;
            end else if (ret_phase_reg) begin
                pc_redirect.target <= stack_rd_data;
            end
        end
    end

    // ---------------- sleep and wake ----------------
    assign wake_limit = (FAST_BOOT || option_reg[evt_ctrl_pkg::OPT_FAST_BIT]) ?
                        evt_ctrl_pkg::WAKE_FAST : evt_ctrl_pkg::WAKE_NORMAL;
    assign pin_toggle = |((pin_rise[6:1] | pin_fall[6:1]) & pin_wake_reg &
                          ~pin_is_output);
    assign light_wake = pin_toggle || (|(timer_hit & ~timer_on_sysclk)) ||
                        (cmp_event && cmp_ctrl_reg[evt_ctrl_pkg::CMP_EN_BIT] &&
                         cmp_sel_reg[evt_ctrl_pkg::CMP_WAKE_BIT]);

    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            evt_ctrl_pkg::PWR_RUN: begin
                if (cmd[evt_ctrl_pkg::CMD_DEEP]) begin
                    pwr_next = evt_ctrl_pkg::PWR_DEEP;
                end else if (cmd[evt_ctrl_pkg::CMD_LIGHT]) begin
                    pwr_next = evt_ctrl_pkg::PWR_LIGHT;
                end
            end
            evt_ctrl_pkg::PWR_LIGHT: begin
                if (light_wake) begin
                    pwr_next = evt_ctrl_pkg::PWR_WAKE;
                end
            end
            evt_ctrl_pkg::PWR_DEEP: begin
                if (pin_toggle) begin
                    pwr_next = evt_ctrl_pkg::PWR_WAKE;
                end
            end
            evt_ctrl_pkg::PWR_WAKE: begin
                if (lrc_tick && wake_cnt_reg == wake_limit - 12'h001) begin
                    pwr_next = evt_ctrl_pkg::PWR_RUN;
                end
            end
            default: pwr_next = evt_ctrl_pkg::PWR_RUN;
        endcase
        if (wdt_fire) begin
            pwr_next = evt_ctrl_pkg::PWR_RUN;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pwr_reg <= evt_ctrl_pkg::PWR_RUN;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // the wake delay is timed on the slow RC clock, which must still be running
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wake_cnt_reg <= 12'h000;
        end else if (pwr_reg != evt_ctrl_pkg::PWR_WAKE) begin
            wake_cnt_reg <= 12'h000;
        end else if (lrc_tick) begin
            wake_cnt_reg <= wake_cnt_reg + 12'h001;
        end
    end

    // clock and power controls follow the next state, so they line up with it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sys_clk_en <= 1'b1;
            osc_stop <= 1'b0;
            prog_mem_off <= 1'b0;
            timer_run <= 5'h1F;
        end else begin
            sys_clk_en <= (pwr_next == evt_ctrl_pkg::PWR_RUN);
            osc_stop <= (pwr_next == evt_ctrl_pkg::PWR_DEEP);
            prog_mem_off <= (pwr_next != evt_ctrl_pkg::PWR_RUN);
            if (pwr_next == evt_ctrl_pkg::PWR_DEEP) begin
                timer_run <= 5'h00;
            end else if (pwr_next == evt_ctrl_pkg::PWR_RUN) begin
                timer_run <= timer_osc_on;
            end else begin
                timer_run <= timer_osc_on & ~timer_on_sysclk;
            end
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence irq_entry_s;
        take_irq;
    endsequence

    sequence reti_pop_s;
        cmd[evt_ctrl_pkg::CMD_RETI] ##1 stack_req.rd_en;
    endsequence

    wdt_timeout_a: assert property (wdt_fire |=> chip_reset && wdt_cnt_reg == 18'h00000
        && pc_redirect.load && pc_redirect.target == evt_ctrl_pkg::RESET_VECTOR)
        else $error("watchdog timeout did not reset");
    wdt_clear_a: assert property (cmd[evt_ctrl_pkg::CMD_WDT_CLR] |=>
        wdt_cnt_reg == 18'h00000)
        else $error("watchdog clear ignored");
    entry_push_a: assert property (irq_entry_s |=> stack_req.wr_en
        && stack_req.addr == $past(sp_reg) && stack_req.wdata == $past(cpu_pc)
        && sp_reg == $past(sp_reg) + 8'h02 && !gie_reg)
        else $error("interrupt entry push wrong");
    entry_vector_a: assert property (irq_entry_s |=> pc_redirect.load
        && pc_redirect.target == evt_ctrl_pkg::IRQ_VECTOR)
        else $error("interrupt entry vector wrong");
    reti_pop_a: assert property (reti_pop_s |-> sp_reg == $past(sp_reg, 1) - 8'h02
        && gie_reg ##1 pc_redirect.load && pc_redirect.target == $past(stack_rd_data))
        else $error("return pop wrong");
    flag_set_a: assert property ((|events) |=>
        (irq_req_reg & $past(events)) == $past(events))
        else $error("request flag lost");
    boundary_only_a: assert property (stack_req.wr_en |-> $past(cpu_boundary)
        && $past(gie_reg))
        else $error("interrupt taken off boundary");
    sleep_clock_a: assert property ((pwr_reg == evt_ctrl_pkg::PWR_LIGHT
        || pwr_reg == evt_ctrl_pkg::PWR_DEEP) |-> !sys_clk_en)
        else $error("system clock on in sleep");
    deep_pin_only_a: assert property (pwr_reg == evt_ctrl_pkg::PWR_DEEP && !pin_toggle
        && !wdt_fire |=> pwr_reg == evt_ctrl_pkg::PWR_DEEP)
        else $error("deep sleep woke without pin");
    wake_delay_a: assert property (pwr_reg == evt_ctrl_pkg::PWR_WAKE && lrc_tick
        && wake_cnt_reg == wake_limit - 12'h001 |=> pwr_reg == evt_ctrl_pkg::PWR_RUN
        && sys_clk_en)
        else $error("wake delay wrong");
    fast_boot_a: assert property (FAST_BOOT |-> wake_limit == evt_ctrl_pkg::WAKE_FAST)
        else $error("fast boot not forced");
endmodule : evt_ctrl
`default_nettype wire

// file: evt_ctrl_tb_top.sv
// self-checking bench for the watchdog, interrupt and sleep controller
`timescale 1ns/1ps
`default_nettype none
module evt_ctrl_tb_top;
    logic clk, reset, cyc, stb, we, lrc, ext, bnd, wb_ack_o, chip_reset;
    logic sys_clk_en, osc_stop, prog_mem_off, cmpe;
    logic prev_en = 1'b1;
    logic [5:0] adr, wpin, pout;
    logic [31:0] wdat, wb_dat_o;
    logic [15:0] pc, srd;
    logic [4:0] hit, timer_run, tsys;
    logic [3:0] src, sel;
    logic [1:0] slow = 2'h0;
    evt_ctrl_pkg::stack_req_t stack_req;
    evt_ctrl_pkg::pc_redirect_t pc_redirect;
    logic [31:0] rd_q[$];
    logic [23:0] st_q[$];
    logic [15:0] pc_q[$];
    logic [7:0] pw_q[$];
    int n_mismatch, compares, seed, n;

    evt_ctrl #(.FAST_BOOT(1'b0)) dut_u (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .low_speed_rc_osc(lrc),
        .ext_irq_pin(ext), .wake_pin(wpin), .pin_is_output(pout), .src_level(src),
        .cpu_boundary(bnd), .cpu_pc(pc), .stack_rd_data(srd), .timer_hit(hit),
        .timer_on_sysclk(tsys), .timer_osc_on(5'h1F), .cmp_event(cmpe),
        .chip_reset(chip_reset), .stack_req(stack_req), .pc_redirect(pc_redirect),
        .sys_clk_en(sys_clk_en), .osc_stop(osc_stop), .prog_mem_off(prog_mem_off),
        .timer_run(timer_run));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // slow oscillator at a quarter of the system rate keeps long counts short
    assign lrc = slow[1];
    always @(posedge clk) begin
        slow <= slow + 2'h1;
        bnd <= 1'($random(seed));
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // results without a pending note compare against unknown and so fail
    always @(posedge clk) begin
        if (wb_ack_o === 1'b1 && we === 1'b0)
            cmp(wb_dat_o, rd_q.size() ? rd_q.pop_front() : 32'hX);
        if (stack_req.wr_en === 1'b1)
            cmp({stack_req.addr, stack_req.wdata}, st_q.size() ? st_q.pop_front() : 24'hX);
        if (stack_req.rd_en === 1'b1)
            cmp({stack_req.addr, 16'h0}, st_q.size() ? st_q.pop_front() : 24'hX);
        if (pc_redirect.load === 1'b1)
            cmp(pc_redirect.target, pc_q.size() ? pc_q.pop_front() : 16'hX);
        if (sys_clk_en !== prev_en)
            cmp({sys_clk_en, osc_stop, prog_mem_off, timer_run},
                pw_q.size() ? pw_q.pop_front() : 8'hX);
        prev_en <= sys_clk_en;
    end

    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        wb(1'b0, a, 32'h0);
    endtask : rd

    task automatic src_pulse();
        src[0] <= 1'b1;
        repeat (6) @(posedge clk);
        src[0] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : src_pulse

    task automatic wait_wake(input int lo, input int hi);
        n = 0;
        while (sys_clk_en !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        cmp(32'(n >= lo && n <= hi), 32'h1);
    endtask : wait_wake

    task automatic end_sim();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    initial begin
        #(8 * 60000);
        n_mismatch++;
        end_sim();
    end

    initial begin
        {n_mismatch, compares, cyc, stb, we, adr, wdat, ext, wpin, hit, src, cmpe} = '0;
        seed = 31;
        sel = 4'hF;
        pout = 6'h02;
        tsys = 5'h06;
        reset = 1'b1;
        pc = 16'($random(seed));
        srd = 16'($random(seed));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd(evt_ctrl_pkg::ADR_OPTION, 32'h0);
        rd(evt_ctrl_pkg::ADR_IRQ_EN, 32'h0);
        wb(1'b1, evt_ctrl_pkg::ADR_EDGE, 32'h8);
        ext <= 1'b1;
        src[0] <= 1'b1;
        repeat (6) @(posedge clk);
        rd(evt_ctrl_pkg::ADR_IRQ_REQ, 32'h1);
        src[0] <= 1'b0;
        repeat (6) @(posedge clk);
        rd(evt_ctrl_pkg::ADR_IRQ_REQ, 32'h3);
        wb(1'b1, evt_ctrl_pkg::ADR_IRQ_REQ, 32'h0);
        rd(evt_ctrl_pkg::ADR_IRQ_REQ, 32'h0);
        wb(1'b1, evt_ctrl_pkg::ADR_IRQ_EN, 32'h2);
        wb(1'b1, evt_ctrl_pkg::ADR_SP, 32'h20);
        src_pulse();
        pc_q.push_back(evt_ctrl_pkg::IRQ_VECTOR);
        st_q.push_back({8'h20, pc});
        wb(1'b1, evt_ctrl_pkg::ADR_CMD, 32'h2);
        repeat (20) @(posedge clk);
        rd(evt_ctrl_pkg::ADR_SP, 32'h22);
        rd(evt_ctrl_pkg::ADR_STATUS, 32'h10);
        wb(1'b1, evt_ctrl_pkg::ADR_IRQ_REQ, 32'h0);
        st_q.push_back({8'h20, 16'h0});
        pc_q.push_back(srd);
        wb(1'b1, evt_ctrl_pkg::ADR_CMD, 32'h20);
        rd(evt_ctrl_pkg::ADR_SP, 32'h20);
        rd(evt_ctrl_pkg::ADR_STATUS, 32'h11);
        wb(1'b1, evt_ctrl_pkg::ADR_OPTION, 32'h20);
        wb(1'b1, evt_ctrl_pkg::ADR_PIN_WAKE, 32'h3);
        wb(1'b1, evt_ctrl_pkg::ADR_CMP_CTRL, 32'h80);
        pw_q.push_back(8'h39);
        wb(1'b1, evt_ctrl_pkg::ADR_CMD, 32'h8);
        // a system-clocked timer hit and an unselected comparator event must not wake
        hit <= 5'h02;
        cmpe <= 1'b1;
        repeat (40) @(posedge clk);
        pw_q.push_back(8'h9F);
        hit <= 5'h01;
        cmpe <= 1'b0;
        @(posedge clk);
        hit <= 5'h00;
        wait_wake(170, 200);
        wb(1'b1, evt_ctrl_pkg::ADR_CMP_CTRL, 32'h0);
        pw_q.push_back(8'h60);
        wb(1'b1, evt_ctrl_pkg::ADR_CMD, 32'h10);
        repeat (10) @(posedge clk);
        hit <= 5'h01;
        wpin[1] <= 1'b1;
        repeat (300) @(posedge clk);
        hit <= 5'h00;
        pw_q.push_back(8'h9F);
        wpin[0] <= 1'b1;
        wait_wake(170, 200);
        pc_q.push_back(evt_ctrl_pkg::RESET_VECTOR);
        wb(1'b1, evt_ctrl_pkg::ADR_CMD, 32'h1);
        n = 0;
        while (chip_reset !== 1'b1 && n < 40000) begin
            @(posedge clk);
            n++;
        end
        cmp(32'(n >= 32700 && n <= 32800), 32'h1);
        repeat (5) @(posedge clk);
        end_sim();
    end
endmodule : evt_ctrl_tb_top
`default_nettype wire
